// *** rtl/subghz_transceiver_config_regs.v ***
`include "radio_cfg_defines.vh"
module subghz_transceiver_config_regs (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  output wire err_o,
  // status from the radio
  input wire [7:0] signal_strength_i,
  input wire crc_ok_i,
  // decoded mode
  output wire transmit_mode_o,
  output wire receive_mode_o,
  output wire synth_mode_o,
  output wire standby_mode_o,
  output wire sleep_mode_o,
  output wire mode_reserved_o,
  // general configuration fields
  output wire [2:0] chip_operating_mode_o,
  output wire [1:0] frequency_band_select_o,
  output wire band_reserved_o,
  output wire [1:0] vco_tune_trim_o,
  output reg [7:0] vco_offset_mv_o,
  output wire pll_divider_set_select_o,
  // upper configuration bytes
  output wire [7:0] onoff_keying_config_o,
  output wire [31:0] sync_word_o,
  output wire [7:0] transmit_config_o,
  output wire [7:0] payload_config_o,
  output wire [7:0] local_node_address_o,
  output wire [7:0] packet_config_o,
  output wire [7:0] fifo_crc_config_o
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  reg [7:0] rssi_meta;
  reg [7:0] rssi_sync;
  reg [7:0] rssi_last;
  reg [7:0] rssi_held;
  reg crc_meta;
  reg crc_sync;
  // strength word taken only once two samples agree, so a read
  // never mixes bits of two different measurements
  always @(posedge clk_i) begin
    if (rst_i) begin
      rssi_meta <= 8'h00;
      rssi_sync <= 8'h00;
      rssi_last <= 8'h00;
      rssi_held <= 8'h00;
      crc_meta <= 1'b0;
      crc_sync <= 1'b0;
    end else begin
      rssi_meta <= signal_strength_i;
      rssi_sync <= rssi_meta;
      rssi_last <= rssi_sync;
      if (rssi_sync == rssi_last) begin
        rssi_held <= rssi_sync;
      end
      crc_meta <= crc_ok_i;
      crc_sync <= crc_meta;
    end
  end

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire [5:0] index = adr_i[7:2];
  wire req = cyc_i & stb_i;
  wire lane0 = sel_i[0];
  reg hit;
  always @* begin
    case ({2'b00, index})
      `IDX_GENERAL_CONFIG, `IDX_SIGNAL_STRENGTH, `IDX_ONOFF_KEYING,
      `IDX_SYNC_BYTE1, `IDX_SYNC_BYTE2, `IDX_SYNC_BYTE3,
      `IDX_SYNC_BYTE4, `IDX_TRANSMIT_CONFIG, `IDX_PAYLOAD_CONFIG,
      `IDX_NODE_ADDRESS, `IDX_PACKET_CONFIG,
      `IDX_FIFO_CRC_CONFIG: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  wire ack_any;
  wb_slave_ack u_ack (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .ack_o(ack_any)
  );
  reg hit_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      hit_q <= 1'b0;
    end else begin
      hit_q <= hit;
    end
  end
  // unmapped offsets answer with err instead of ack
  assign ack_o = ack_any & hit_q;
  assign err_o = ack_any & ~hit_q;

  // writes land on the edge where the master samples ack, never before
  wire wr_strobe = req & we_i & ack_any & lane0 & hit;

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  localparam NREG = 11;
  wire [7:0] reg_idx [0:NREG-1];
  assign reg_idx[0] = `IDX_GENERAL_CONFIG;
  assign reg_idx[1] = `IDX_ONOFF_KEYING;
  assign reg_idx[2] = `IDX_SYNC_BYTE1;
  assign reg_idx[3] = `IDX_SYNC_BYTE2;
  assign reg_idx[4] = `IDX_SYNC_BYTE3;
  assign reg_idx[5] = `IDX_SYNC_BYTE4;
  assign reg_idx[6] = `IDX_TRANSMIT_CONFIG;
  assign reg_idx[7] = `IDX_PAYLOAD_CONFIG;
  assign reg_idx[8] = `IDX_NODE_ADDRESS;
  assign reg_idx[9] = `IDX_PACKET_CONFIG;
  assign reg_idx[10] = `IDX_FIFO_CRC_CONFIG;
  wire [7:0] value [0:NREG-1];

  // one write enable per stored byte, from the shared index table
  reg [NREG-1:0] wr_sel;
  integer w;
  always @* begin
    wr_sel = {NREG{1'b0}};
    for (w = 0; w < NREG; w = w + 1) begin
      wr_sel[w] = wr_strobe & ({2'b00, index} == reg_idx[w]);
    end
  end

  // ----------------------------------------
  // register instances
  // ----------------------------------------
  // general configuration, standby after reset
  cfg_byte_reg #(
    .RESET_VALUE(`RST_GENERAL_CONFIG)
  ) u_general (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[0]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[0])
  );

  // on-off keying threshold settings
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_onoff_keying (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[1]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[1])
  );

  // first sync byte
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_sync_byte1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[2]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[2])
  );

  // second sync byte
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_sync_byte2 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[3]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[3])
  );

  // third sync byte
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_sync_byte3 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[4]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[4])
  );

  // fourth sync byte
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_sync_byte4 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[5]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[5])
  );

  // transmit configuration
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_transmit (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[6]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[6])
  );

  // payload configuration
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_payload (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[7]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[7])
  );

  // local node address
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_node_address (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[8]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[8])
  );

  // packet configuration, crc status bit is read-only
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_packet (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[9]),
    .data_i(dat_i[7:0]),
    .mask_i(~(8'h01 << `PKT_CRC_OK_BIT)),
    .value_o(value[9])
  );

  // fifo and crc handling
  cfg_byte_reg #(
    .RESET_VALUE(`RST_ZERO)
  ) u_fifo_crc (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_sel[10]),
    .data_i(dat_i[7:0]),
    .mask_i(8'hFF),
    .value_o(value[10])
  );

  // ----------------------------------------
  // general configuration decode
  // ----------------------------------------
  wire [7:0] gen = value[0];
  assign chip_operating_mode_o = gen[`MODE_MSB:`MODE_LSB];
  assign transmit_mode_o = chip_operating_mode_o == `MODE_TRANSMIT;
  assign receive_mode_o = chip_operating_mode_o == `MODE_RECEIVE;
  assign synth_mode_o = chip_operating_mode_o == `MODE_SYNTH;
  assign standby_mode_o = chip_operating_mode_o == `MODE_STANDBY;
  assign sleep_mode_o = chip_operating_mode_o == `MODE_SLEEP;
  // reserved codes drive no mode at all
  assign mode_reserved_o = chip_operating_mode_o > `MODE_TRANSMIT;
  assign frequency_band_select_o = gen[`BAND_MSB:`BAND_LSB];
  assign band_reserved_o = frequency_band_select_o == `BAND_RESERVED;
  assign vco_tune_trim_o = gen[`TRIM_MSB:`TRIM_LSB];
  assign pll_divider_set_select_o = gen[`DIVSEL_BIT];

  // typical offset in mV, for the analog trim DAC
  always @(posedge clk_i) begin
    if (rst_i) begin
      vco_offset_mv_o <= 8'h00;
    end else begin
      case (vco_tune_trim_o)
        2'h3: vco_offset_mv_o <= 8'hB4;
        2'h2: vco_offset_mv_o <= 8'h78;
        2'h1: vco_offset_mv_o <= 8'h3C;
        default: vco_offset_mv_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // upper configuration outputs
  // ----------------------------------------
  assign onoff_keying_config_o = value[1];
  // first byte leads the word on air
  assign sync_word_o = {value[2], value[3], value[4], value[5]};
  assign transmit_config_o = value[6];
  assign payload_config_o = value[7];
  assign local_node_address_o = value[8];
  assign packet_config_o = value[9];
  assign fifo_crc_config_o = value[10];

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  reg [7:0] rd;
  integer k;
  always @* begin
    rd = 8'h00;
    if ({2'b00, index} == `IDX_SIGNAL_STRENGTH) begin
      rd = rssi_held;
    end
    for (k = 0; k < NREG; k = k + 1) begin
      if ({2'b00, index} == reg_idx[k]) begin
        rd = value[k];
      end
    end
    if ({2'b00, index} == `IDX_PACKET_CONFIG) begin
      rd = {value[9][7:1], crc_sync};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (req & ~we_i & ~ack_any) begin
      dat_o <= {24'h000000, rd};
    end
  end
endmodule // subghz_transceiver_config_regs

// *** rtl/radio_cfg_defines.vh ***
`ifndef RADIO_CFG_DEFINES_VH
`define RADIO_CFG_DEFINES_VH
// How it works
// - mode field codes 100 transmit, 011 receive, 010 synthesizer.
// - general configuration register resets to 0x28, standby mode.
// - band code 11 reserved; code 10 selects the 950 MHz band.
// - trim codes 11, 10, 01 offset tuning by 180, 120, 60 mV.
// - sync word built from bytes at 0x16..0x19, lowest address first.
// - register 0x14 reads live signal strength measurement.
// - register 0x15 holds on-off keying threshold settings.
// - register 0x1C holds Manchester enable and payload length.
// - register 0x1D holds local node address for filtering.
// - register 0x1E holds packet format bits and reads crc status.
// - register 0x1F holds fifo auto-clear on crc fail and access.
// - reset loads defaults into every register.

// ----------------------------------------
// offsets (byte addresses = index * 4)
// ----------------------------------------
`define IDX_GENERAL_CONFIG 8'h00
`define IDX_SIGNAL_STRENGTH 8'h14
`define IDX_ONOFF_KEYING 8'h15
`define IDX_SYNC_BYTE1 8'h16
`define IDX_SYNC_BYTE2 8'h17
`define IDX_SYNC_BYTE3 8'h18
`define IDX_SYNC_BYTE4 8'h19
`define IDX_TRANSMIT_CONFIG 8'h1A
`define IDX_PAYLOAD_CONFIG 8'h1C
`define IDX_NODE_ADDRESS 8'h1D
`define IDX_PACKET_CONFIG 8'h1E
`define IDX_FIFO_CRC_CONFIG 8'h1F

// ----------------------------------------
// fields of general configuration
// ----------------------------------------
`define MODE_MSB 7
`define MODE_LSB 5
`define BAND_MSB 4
`define BAND_LSB 3
`define TRIM_MSB 2
`define TRIM_LSB 1
`define DIVSEL_BIT 0
`define MODE_TRANSMIT 3'h4
`define MODE_RECEIVE 3'h3
`define MODE_SYNTH 3'h2
`define MODE_STANDBY 3'h1
`define MODE_SLEEP 3'h0
`define BAND_RESERVED 2'h3
`define PKT_CRC_OK_BIT 0

// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_GENERAL_CONFIG 8'h28
`define RST_ZERO 8'h00
`endif

// *** rtl/cfg_byte_reg.v ***
`include "radio_cfg_defines.vh"
module cfg_byte_reg #(
  parameter [7:0] RESET_VALUE = `RST_ZERO
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // write side
  input wire wr_i,
  input wire [7:0] data_i,
  input wire [7:0] mask_i,
  // stored value
  output reg [7:0] value_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      value_o <= RESET_VALUE;
    end else if (wr_i) begin
      value_o <= data_i & mask_i;
    end
  end
endmodule // cfg_byte_reg

// *** rtl/wb_slave_ack.v ***
module wb_slave_ack (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // bus request
  input wire cyc_i,
  input wire stb_i,
  // one-cycle answer
  output reg ack_o
);
  // ack drops the cycle after it was given
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end
endmodule // wb_slave_ack

// *** tb/radio_cfg_assertions.sv ***
module radio_cfg_checker (
  // clock and bus
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  input wire ack_o,
  input wire err_o,
  // configuration outputs
  input wire transmit_mode_o,
  input wire receive_mode_o,
  input wire synth_mode_o,
  input wire [2:0] chip_operating_mode_o,
  input wire [1:0] frequency_band_select_o,
  input wire band_reserved_o,
  input wire [1:0] vco_tune_trim_o,
  input wire [7:0] vco_offset_mv_o,
  input wire pll_divider_set_select_o,
  input wire [31:0] sync_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire [2:0] m = chip_operating_mode_o;
  wire [7:0] cfg = {m, frequency_band_select_o, vco_tune_trim_o,
    pll_divider_set_select_o};
  wire wr_gen = cyc_i && stb_i && we_i && sel_i[0] && adr_i == 8'h00;
  wire wr_sync = cyc_i && stb_i && we_i && sel_i[0] && adr_i == 8'h58;
  // ----------
  // properties
  // ----------
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (cyc_i && stb_i && !ack_o && !err_o
    |=> ack_o || err_o)
    else $error("no answer one cycle after request");
  reset_value_a: assert property ($fell(rst_i) |-> cfg == 8'h28)
    else $error("general config not at reset value");
  mode_decode_a: assert property ({transmit_mode_o, receive_mode_o,
    synth_mode_o} == {m == 3'h4, m == 3'h3, m == 3'h2})
    else $error("mode decode wrong");
  band_flag_a: assert property (band_reserved_o ==
    (frequency_band_select_o == 2'h3))
    else $error("band flag wrong");
  trim_offset_a: assert property (vco_offset_mv_o ==
    8'h3C * $past(vco_tune_trim_o))
    else $error("trim offset wrong");
  write_effect_a: assert property (ack_o && wr_gen
    |=> cfg == $past(dat_i[7:0]))
    else $error("written config not shown");
  sync_order_a: assert property (ack_o && wr_sync
    |=> sync_word_o[31:24] == $past(dat_i[7:0]))
    else $error("first sync byte not on top");
  cover property (ack_o && we_i);
  cover property (err_o);
  cover property (transmit_mode_o);
endmodule // radio_cfg_checker

bind subghz_transceiver_config_regs radio_cfg_checker chk (.*);

// *** tb/test_subghz_transceiver_config_regs.sv ***
module test_subghz_transceiver_config_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, crc_ok_i = 0;
  logic [7:0] adr_i = 8'h00, signal_strength_i = 8'h00, vco_offset_mv_o;
  logic [3:0] sel_i = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, sync_word_o, lfsr_state = 32'h7486;
  logic ack_o, err_o, transmit_mode_o, receive_mode_o, synth_mode_o;
  logic standby_mode_o, sleep_mode_o, mode_reserved_o;
  logic [2:0] chip_operating_mode_o;
  logic [7:0] onoff_keying_config_o, transmit_config_o, payload_config_o;
  logic [7:0] local_node_address_o, packet_config_o, fifo_crc_config_o;
  logic [33:0] notes[$], note;
  logic [7:0] rw[9] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1C,
    8'h1D, 8'h1F};
  logic [7:0] exp_b[9];
  logic [7:0] offs[4] = '{8'h00, 8'h3C, 8'h78, 8'hB4};
  int mismatches = 0, cmp_count = 0;
  subghz_transceiver_config_regs uut (.*, .frequency_band_select_o(),
    .band_reserved_o(), .vco_tune_trim_o(), .pll_divider_set_select_o());
  initial forever #4 clk_i = ~clk_i;
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tally_and_finish(bit hung);
    if (hung) mismatches++;
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // waits for ack or err, bounded so a dead slave cannot hang the run
  task automatic bus(logic w, logic [7:0] i, logic [7:0] d, logic [33:0] n);
    int k;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= {i[5:0], 2'b00};
    dat_i <= {24'h0, d};
    notes.push_back(n);
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (!(ack_o | err_o) && k < 50);
    if (k >= 50) tally_and_finish(1);
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task automatic rd(logic [7:0] i, logic [7:0] e, bit bad = 0);
    bus(0, i, 8'h00, {bad, 1'b1, 24'h0, e});
  endtask
  task automatic wr(logic [7:0] i, logic [7:0] d);
    bus(1, i, d, 34'h0);
  endtask
  always @(posedge clk_i) begin
    if (ack_o | err_o) begin
      note = notes.pop_front();
      chk("err_o", note[33], err_o);
      if (note[32]) chk("dat_o", {24'h0, note[7:0]}, dat_o);
    end
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("standby", 1, standby_mode_o);
    rd(8'h00, 8'h28);
    foreach (rw[j]) rd(rw[j], 8'h00);
    $display("reset values done");
    foreach (rw[j]) begin
      lfsr_state = lfsr(lfsr_state);
      exp_b[j] = lfsr_state[7:0];
      wr(rw[j], exp_b[j]);
    end
    foreach (rw[j]) rd(rw[j], exp_b[j]);
    chk("sync", {exp_b[1], exp_b[2], exp_b[3], exp_b[4]}, sync_word_o);
    chk("cfg", {exp_b[0], exp_b[5], exp_b[6], exp_b[7]},
      {onoff_keying_config_o, transmit_config_o, payload_config_o,
      local_node_address_o});
    chk("fifo_crc", exp_b[8], fifo_crc_config_o);
    $display("read back done");
    // reserved mode codes are never written
    for (int m = 0; m <= 4; m++) begin
      wr(8'h00, {m[2:0], 2'b10, m[1:0], m[0]});
      repeat (2) @(posedge clk_i);
      chk("mode", m, chip_operating_mode_o);
      chk("tx", m == 4, transmit_mode_o);
      chk("rx", m == 3, receive_mode_o);
      chk("synth", m == 2, synth_mode_o);
      chk("idle", {m == 1, m == 0}, {standby_mode_o, sleep_mode_o});
      chk("reserved", 0, mode_reserved_o);
      chk("offset", offs[m[1:0]], vco_offset_mv_o);
    end
    $display("modes done");
    lfsr_state = lfsr(lfsr_state);
    signal_strength_i <= lfsr_state[7:0];
    wr(8'h1E, 8'hFF);
    wr(8'h14, 8'h55);
    repeat (3) @(posedge clk_i);
    chk("pkt", 8'hFE, packet_config_o);
    rd(8'h14, lfsr_state[7:0]);
    rd(8'h1E, 8'hFE);
    crc_ok_i <= 1;
    repeat (3) @(posedge clk_i);
    rd(8'h1E, 8'hFF);
    rd(8'h01, 8'h00, 1);
    repeat (2) @(posedge clk_i);
    $display("status and unmapped done");
    tally_and_finish(0);
  end
endmodule // test_subghz_transceiver_config_regs
